// ==== rtl/dpmb_pkg.sv ====
// ==========================================================
// Shared constants of the debug port mailbox
package dpmb_pkg;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTL = 8'h06;
   localparam logic [7:0] IDX_IN0 = 8'h08;
   localparam logic [7:0] IDX_IN1 = 8'h0A;
   localparam logic [7:0] IDX_OUT0 = 8'h0C;
   localparam logic [7:0] IDX_OUT1 = 8'h0E;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h10;
   localparam logic [7:0] IDX_IRQ_CLR = 8'h11;
   localparam logic [7:0] IDX_IRQ_EN = 8'h12;
   // Control register field positions
   localparam int BIT_IN0_NEW = 0;
   localparam int BIT_IN1_NEW = 1;
   localparam int BIT_OUT0_RDY = 2;
   localparam int BIT_OUT1_RDY = 3;
   localparam int BIT_WIDTH_SEL = 4;
   localparam int BIT_IN0_ACOFF = 6;
   localparam int BIT_IN1_ACOFF = 7;
   // Interrupt status layout
   localparam int IRQ_IN0 = 0;
   localparam int IRQ_IN1 = 1;
   localparam int IRQ_OUT0 = 2;
   localparam int IRQ_OUT1 = 3;
   localparam int IRQ_W = 4;
   // Reset values
   localparam logic [15:0] MSG_RST = 16'h0000;
   localparam logic RDY_RST = 1'b1;
   localparam logic NEW_RST = 1'b0;
   localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
endpackage

// ==== rtl/dpmb_flag.sv ====
`timescale 1ns/1ps
// ==========================================================
// One sticky flag, set beats clear in the same cycle
module dpmb_flag #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);
   logic flag_q;
   logic flag_d;

   // Next value with set priority
   always_comb begin
      flag_d = flag_q;
      if (set_i) begin
         flag_d = 1'b1;
      end else if (clr_i) begin
         flag_d = 1'b0;
      end
   end

   // Flag storage
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flag_q <= RST_VAL;
      end else if (ce_i) begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;
endmodule

// ==== rtl/dpmb_top.sv ====
// The implementer's own choices: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module dpmb_top (
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic irq_o,
   input wire logic host_in_wr0_i,
   input wire logic host_in_wr1_i,
   input wire logic [15:0] host_in_data_i,
   input wire logic host_out_rd0_i,
   input wire logic host_out_rd1_i,
   output logic [15:0] host_out_msg0_o,
   output logic [15:0] host_out_msg1_o,
   output logic host_in0_new_o,
   output logic host_in1_new_o,
   output logic host_out0_rdy_o,
   output logic host_out1_rdy_o,
   output logic host_wide_o
);
   // ==========================================================
   // Bus decode
   logic ack_q;
   logic ack_d;
   logic access;
   logic wr;
   logic rd;
   logic [7:0] idx;
   logic [31:0] rdat_q;
   logic [31:0] rdat_d;

   assign access = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr = access && wb_we_i;
   assign rd = access && !wb_we_i;
   assign idx = wb_adr_i[9:2];

   // ==========================================================
   // Register storage
   logic [15:0] in0_q;
   logic [15:0] in0_d;
   logic [15:0] in1_q;
   logic [15:0] in1_d;
   logic [15:0] out0_q;
   logic [15:0] out0_d;
   logic [15:0] out1_q;
   logic [15:0] out1_d;
   logic in0_acoff_q;
   logic in0_acoff_d;
   logic in1_acoff_q;
   logic in1_acoff_d;
   logic wide_q;
   logic wide_d;
   logic [dpmb_pkg::IRQ_W-1:0] irq_en_q;
   logic [dpmb_pkg::IRQ_W-1:0] irq_en_d;
   logic ctl_wr_lo;
   logic host_wr1;
   logic host_rd1;

   assign ctl_wr_lo = wr && idx == dpmb_pkg::IDX_CTL && wb_sel_i[0];
   // Channel 1 is dormant in 16-bit mode
   assign host_wr1 = host_in_wr1_i && wide_q;
   assign host_rd1 = host_out_rd1_i && wide_q;

   // Flag set and clear terms, event order matches status layout
   logic [3:0] fl_set;
   logic [3:0] fl_clr;
   logic [3:0] fl_q;

   always_comb begin
      fl_set[dpmb_pkg::IRQ_IN0] = host_in_wr0_i;
      fl_set[dpmb_pkg::IRQ_IN1] = host_wr1;
      fl_set[dpmb_pkg::IRQ_OUT0] = host_out_rd0_i;
      fl_set[dpmb_pkg::IRQ_OUT1] = host_rd1;
      // Software may also set the incoming flags by write
      if (ctl_wr_lo) begin
         fl_set[dpmb_pkg::IRQ_IN0] = fl_set[dpmb_pkg::IRQ_IN0] ||
            wb_dat_i[dpmb_pkg::BIT_IN0_NEW];
         fl_set[dpmb_pkg::IRQ_IN1] = fl_set[dpmb_pkg::IRQ_IN1] ||
            wb_dat_i[dpmb_pkg::BIT_IN1_NEW];
      end
      // Read clear when auto-clear is on, software clear at any time
      fl_clr[dpmb_pkg::IRQ_IN0] =
         (rd && idx == dpmb_pkg::IDX_IN0 && !in0_acoff_q) ||
         (ctl_wr_lo && !wb_dat_i[dpmb_pkg::BIT_IN0_NEW]);
      fl_clr[dpmb_pkg::IRQ_IN1] =
         (rd && idx == dpmb_pkg::IDX_IN1 && !in1_acoff_q) ||
         (ctl_wr_lo && !wb_dat_i[dpmb_pkg::BIT_IN1_NEW]);
      // High byte or word write marks outgoing word busy
      fl_clr[dpmb_pkg::IRQ_OUT0] =
         wr && idx == dpmb_pkg::IDX_OUT0 && wb_sel_i[1];
      fl_clr[dpmb_pkg::IRQ_OUT1] =
         wr && idx == dpmb_pkg::IDX_OUT1 && wb_sel_i[1];
   end

   // Four mailbox flags; outgoing ready leaves reset set
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_flag
         dpmb_flag #(
            .RST_VAL((g >= 2) ? dpmb_pkg::RDY_RST :
               dpmb_pkg::NEW_RST)
         ) u_flag (
            .clock_i(clock_i),
            .nrst_i(nrst_i),
            .ce_i(ce_i),
            .set_i(fl_set[g]),
            .clr_i(fl_clr[g]),
            .flag_o(fl_q[g])
         );
      end
   endgenerate

   // Next values of message and control storage
   always_comb begin
      in0_d = in0_q;
      in1_d = in1_q;
      out0_d = out0_q;
      out1_d = out1_q;
      in0_acoff_d = in0_acoff_q;
      in1_acoff_d = in1_acoff_q;
      wide_d = wide_q;
      irq_en_d = irq_en_q;
      // Incoming words are loaded only by the host
      if (host_in_wr0_i) begin
         in0_d = host_in_data_i;
      end
      if (host_wr1) begin
         in1_d = host_in_data_i;
      end
      if (wr && idx == dpmb_pkg::IDX_OUT0) begin
         if (wb_sel_i[0]) out0_d[7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1]) out0_d[15:8] = wb_dat_i[15:8];
      end
      if (wr && idx == dpmb_pkg::IDX_OUT1) begin
         if (wb_sel_i[0]) out1_d[7:0] = wb_dat_i[7:0];
         if (wb_sel_i[1]) out1_d[15:8] = wb_dat_i[15:8];
      end
      // Only bits 7, 6 and 4 are stored here; bits 1 and 0 set or clear the incoming flags, the rest is dropped
      if (ctl_wr_lo) begin
         in1_acoff_d = wb_dat_i[dpmb_pkg::BIT_IN1_ACOFF];
         in0_acoff_d = wb_dat_i[dpmb_pkg::BIT_IN0_ACOFF];
         wide_d = wb_dat_i[dpmb_pkg::BIT_WIDTH_SEL];
      end
      if (wr && idx == dpmb_pkg::IDX_IRQ_EN && wb_sel_i[0]) begin
         irq_en_d = wb_dat_i[dpmb_pkg::IRQ_W-1:0];
      end
   end

   // Message and control registers
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         in0_q <= dpmb_pkg::MSG_RST;
         in1_q <= dpmb_pkg::MSG_RST;
         out0_q <= dpmb_pkg::MSG_RST;
         out1_q <= dpmb_pkg::MSG_RST;
         in0_acoff_q <= 1'b0;
         in1_acoff_q <= 1'b0;
         wide_q <= 1'b0;
         irq_en_q <= dpmb_pkg::IRQ_RST;
      end else if (ce_i) begin
         in0_q <= in0_d;
         in1_q <= in1_d;
         out0_q <= out0_d;
         out1_q <= out1_d;
         in0_acoff_q <= in0_acoff_d;
         in1_acoff_q <= in1_acoff_d;
         wide_q <= wide_d;
         irq_en_q <= irq_en_d;
      end
   end

   // ==========================================================
   // Interrupt status, write one to clear, events win
   logic [dpmb_pkg::IRQ_W-1:0] irq_st_q;
   logic [dpmb_pkg::IRQ_W-1:0] irq_st_d;
   logic [dpmb_pkg::IRQ_W-1:0] irq_ev;

   assign irq_ev = {host_rd1, host_out_rd0_i, host_wr1, host_in_wr0_i};

   always_comb begin
      irq_st_d = irq_st_q;
      if (wr && idx == dpmb_pkg::IDX_IRQ_CLR && wb_sel_i[0]) begin
         irq_st_d = irq_st_d & ~wb_dat_i[dpmb_pkg::IRQ_W-1:0];
      end
      irq_st_d = irq_st_d | irq_ev;
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_st_q <= dpmb_pkg::IRQ_RST;
      end else if (ce_i) begin
         irq_st_q <= irq_st_d;
      end
   end

   assign irq_o = |(irq_st_q & irq_en_q);

   // ==========================================================
   // Read mux and acknowledge
   logic [15:0] ctl_val;

   // Reserved bits tie to zero
   assign ctl_val = {8'h00, in1_acoff_q, in0_acoff_q, 1'b0, wide_q,
      fl_q[3], fl_q[2], fl_q[1], fl_q[0]};

   always_comb begin
      ack_d = access;
      rdat_d = 32'h0000_0000;
      if (rd) begin
         unique case (idx)
            dpmb_pkg::IDX_CTL: rdat_d = {16'h0000, ctl_val};
            dpmb_pkg::IDX_IN0: rdat_d = {16'h0000, in0_q};
            dpmb_pkg::IDX_IN1: rdat_d = {16'h0000, in1_q};
            dpmb_pkg::IDX_OUT0: rdat_d = {16'h0000, out0_q};
            dpmb_pkg::IDX_OUT1: rdat_d = {16'h0000, out1_q};
            dpmb_pkg::IDX_IRQ_STAT: rdat_d = {28'h0000000, irq_st_q};
            dpmb_pkg::IDX_IRQ_EN: rdat_d = {28'h0000000, irq_en_q};
            default: rdat_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign host_out_msg0_o = out0_q;
   assign host_out_msg1_o = out1_q;
   assign host_in0_new_o = fl_q[0];
   assign host_in1_new_o = fl_q[1];
   assign host_out0_rdy_o = fl_q[2];
   assign host_out1_rdy_o = fl_q[3];
   assign host_wide_o = wide_q;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   a_in1_autoclr: assert property (ce_i && rd && idx ==
      dpmb_pkg::IDX_IN1 && !in1_acoff_q && !host_wr1 |=> !fl_q[1])
      else $error("in1 flag not cleared by read");
   a_in0_autoclr: assert property (ce_i && rd && idx ==
      dpmb_pkg::IDX_IN0 && !in0_acoff_q && !host_in_wr0_i
      |=> !fl_q[0])
      else $error("in0 flag not cleared by read");
   a_in0_keep_off: assert property (ce_i && rd && in0_acoff_q &&
      fl_q[0] |=> fl_q[0])
      else $error("in0 flag lost with auto-clear off");
   a_narrow_mode: assert property (ce_i && !wide_q && host_in_wr1_i
      |=> $stable(in1_q))
      else $error("channel 1 loaded in narrow mode");
   a_out1_busy: assert property (ce_i && wr && idx == dpmb_pkg::IDX_OUT1
      && wb_sel_i[1] && !host_rd1 |=> !fl_q[3] && wb_ack_o)
      else $error("out1 ready not cleared");
   a_out0_ready: assert property (ce_i && host_out_rd0_i
      |=> fl_q[2] && irq_st_q[dpmb_pkg::IRQ_OUT0])
      else $error("out0 ready not set by host read");
   a_out0_lowbyte: assert property (ce_i && fl_q[2] && !(wr &&
      wb_sel_i[1]) |=> fl_q[2])
      else $error("out0 ready dropped without high write");
   a_in1_set: assert property (ce_i && host_wr1
      |=> fl_q[1] && in1_q == $past(host_in_data_i))
      else $error("in1 message not captured");
   a_ctl_reserved: assert property (ce_i && rd && idx ==
      dpmb_pkg::IDX_CTL |=> wb_dat_o[31:8] == 24'h000000 &&
      !wb_dat_o[5])
      else $error("reserved control bits not zero");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   c_in0_msg: cover property (host_in_wr0_i ##[1:20] rd && idx ==
      dpmb_pkg::IDX_IN0);
   c_out1_wide: cover property (wide_q && fl_clr[3] ##[1:20]
      host_rd1);
   c_irq: cover property (irq_o);
endmodule

// ==== bench/dpmb_host_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Debug host model at the far side of the mailbox
module dpmb_host_model (
   input wire logic clock_i,
   input wire logic in0_new_i,
   input wire logic in1_new_i,
   input wire logic out0_rdy_i,
   input wire logic out1_rdy_i,
   input wire logic [15:0] msg0_i,
   input wire logic [15:0] msg1_i,
   output logic wr0_o,
   output logic wr1_o,
   output logic [15:0] data_o,
   output logic rd0_o,
   output logic rd1_o
);
   // Waits that ran out of time, read by the bench
   int n_late = 0;
   // Idle outputs at time zero
   initial begin
      {wr0_o, wr1_o, rd0_o, rd1_o} = 4'h0;
      data_o = 16'h0000;
   end
   // Write an incoming word once its slot is empty or after 100 cycles of waiting
   task automatic put(input int ch, input logic [15:0] d);
      int n;
      n = 0;
      while ((ch == 0 ? in0_new_i : in1_new_i) !== 1'b0 &&
            n < 100) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 100) n_late++;
      if (ch == 0) wr0_o <= 1'b1;
      else wr1_o <= 1'b1;
      data_o <= d;
      @(posedge clock_i);
      {wr0_o, wr1_o} <= 2'h0;
      data_o <= ~d; // Released bus does not keep the value
      @(posedge clock_i); // Idle edge before the next call
   endtask
   // Read an outgoing word once a message waits or after 100 cycles of waiting
   task automatic get(input int ch, output logic [15:0] d);
      int n;
      n = 0;
      while ((ch == 0 ? out0_rdy_i : out1_rdy_i) !== 1'b0 &&
            n < 100) begin
         @(posedge clock_i);
         n++;
      end
      if (n >= 100) n_late++;
      d = (ch == 0) ? msg0_i : msg1_i;
      if (ch == 0) rd0_o <= 1'b1;
      else rd1_o <= 1'b1;
      @(posedge clock_i);
      {rd0_o, rd1_o} <= 2'h0;
      @(posedge clock_i); // Idle edge before the next call
   endtask
endmodule

// ==== bench/dpmb_top_tb_top.sv ====
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench of the debug port mailbox
module dpmb_top_tb_top;
   logic clock_i = 1'b0, nrst_i = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [31:0] adr = 32'h0, wdat = 32'h0, rdat;
   logic [3:0] sel = 4'h0;
   logic ce = 1'b1;
   logic ack, irq, w0, w1, r0, r1, n0, n1, y0, y1, wide;
   logic [15:0] hd, m0, m1, t;
   int fails = 0, n_tests = 0;
   // Clock generator
   initial forever #25 clock_i = ~clock_i;
   dpmb_top dut (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(ce),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .irq_o(irq), .host_in_wr0_i(w0), .host_in_wr1_i(w1),
      .host_in_data_i(hd), .host_out_rd0_i(r0), .host_out_rd1_i(r1),
      .host_out_msg0_o(m0), .host_out_msg1_o(m1), .host_in0_new_o(n0),
      .host_in1_new_o(n1), .host_out0_rdy_o(y0), .host_out1_rdy_o(y1),
      .host_wide_o(wide));
   dpmb_host_model host (.clock_i(clock_i), .in0_new_i(n0),
      .in1_new_i(n1), .out0_rdy_i(y0), .out1_rdy_i(y1), .msg0_i(m0),
      .msg1_i(m1), .wr0_o(w0), .wr1_o(w1), .data_o(hd), .rd0_o(r0),
      .rd1_o(r1));
   // Compare one value
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic Wishbone cycle, entered just after a rising edge
   task automatic bus(input logic w, input logic [7:0] i, input logic [3:0] s,
         input logic [15:0] d, output logic [15:0] q);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {22'h0, i, 2'h0};
      sel <= s;
      wdat <= {16'h0000, d};
      do begin
         @(posedge clock_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (ack !== 1'b1) begin
         fails++;
         $display("[FAIL] %0t bus cycle not acknowledged", $time);
      end
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [7:0] i, input logic [3:0] s,
         input logic [15:0] d);
      logic [15:0] q;
      bus(1'b1, i, s, d, q);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [15:0] e);
      logic [15:0] q;
      bus(1'b0, i, 4'h3, 16'h0000, q);
      chk(q, e);
   endtask
   // Reset values and an unmapped place
   task automatic t_reset;
      rdc(dpmb_pkg::IDX_CTL, 16'h000C);
      rdc(dpmb_pkg::IDX_IN0, 16'h0000);
      rdc(dpmb_pkg::IDX_IN1, 16'h0000);
      rdc(dpmb_pkg::IDX_OUT0, 16'h0000);
      rdc(dpmb_pkg::IDX_OUT1, 16'h0000);
      rdc(8'h20, 16'h0000);
      chk({y1, y0, wide}, 3'h6);
   endtask
   // Reserved bits ignore writes, ready flag bits read-only, new flag bits writable
   task automatic t_reserved;
      wr(dpmb_pkg::IDX_CTL, 4'h3, 16'hFFFF);
      rdc(dpmb_pkg::IDX_CTL, 16'h00DF);
      chk(wide, 1'b1);
      wr(dpmb_pkg::IDX_CTL, 4'h3, 16'h0000);
      rdc(dpmb_pkg::IDX_CTL, 16'h000C);
   endtask
   // Narrow mode, auto-clear on read, channel 1 unused
   task automatic t_narrow;
      host.put(0, 16'hA55A);
      rdc(dpmb_pkg::IDX_CTL, 16'h000D);
      rdc(dpmb_pkg::IDX_IN0, 16'hA55A);
      rdc(dpmb_pkg::IDX_CTL, 16'h000C);
      host.put(1, 16'h5555);
      rdc(dpmb_pkg::IDX_IN1, 16'h0000);
   endtask
   // Auto-clear disabled, then software and auto clear
   task automatic t_autoclear;
      wr(dpmb_pkg::IDX_CTL, 4'h1, 16'h00D0);
      host.put(0, 16'h1234);
      host.put(1, 16'h5678);
      rdc(dpmb_pkg::IDX_IN0, 16'h1234);
      rdc(dpmb_pkg::IDX_IN1, 16'h5678);
      rdc(dpmb_pkg::IDX_CTL, 16'h00DF);
      wr(dpmb_pkg::IDX_CTL, 4'h1, 16'h00D0);
      rdc(dpmb_pkg::IDX_CTL, 16'h00DC);
      wr(dpmb_pkg::IDX_CTL, 4'h1, 16'h0010);
      host.put(1, 16'h9ABC);
      rdc(dpmb_pkg::IDX_CTL, 16'h001E);
      rdc(dpmb_pkg::IDX_IN1, 16'h9ABC);
      rdc(dpmb_pkg::IDX_CTL, 16'h001C);
   endtask
   // Outgoing words and their ready flags
   task automatic t_out;
      wr(dpmb_pkg::IDX_OUT0, 4'h1, 16'h0077);
      rdc(dpmb_pkg::IDX_CTL, 16'h001C);
      wr(dpmb_pkg::IDX_OUT0, 4'h2, 16'h8800);
      rdc(dpmb_pkg::IDX_CTL, 16'h0018);
      rdc(dpmb_pkg::IDX_OUT0, 16'h8877);
      host.get(0, t);
      chk(t, 16'h8877);
      wr(dpmb_pkg::IDX_OUT1, 4'h3, 16'hBEEF);
      rdc(dpmb_pkg::IDX_CTL, 16'h0014);
      host.get(1, t);
      chk(t, 16'hBEEF);
      rdc(dpmb_pkg::IDX_CTL, 16'h001C);
      wr(dpmb_pkg::IDX_IN0, 4'h3, 16'hFFFF);
      rdc(dpmb_pkg::IDX_IN0, 16'h1234);
   endtask
   // Sticky status, mask and clear of the interrupt
   task automatic t_irq;
      rdc(dpmb_pkg::IDX_IRQ_STAT, 16'h000F);
      wr(dpmb_pkg::IDX_IRQ_CLR, 4'h1, 16'h000F);
      rdc(dpmb_pkg::IDX_IRQ_STAT, 16'h0000);
      host.put(0, 16'h0101);
      rdc(dpmb_pkg::IDX_IRQ_STAT, 16'h0001);
      chk(irq, 1'b0);
      wr(dpmb_pkg::IDX_IRQ_EN, 4'h1, 16'h0001);
      chk(irq, 1'b1);
      rdc(dpmb_pkg::IDX_IRQ_EN, 16'h0001);
      wr(dpmb_pkg::IDX_IRQ_CLR, 4'h1, 16'h0001);
      chk(irq, 1'b0);
      rdc(dpmb_pkg::IDX_IRQ_CLR, 16'h0000);
   endtask
   // Host pulse while the clock enable is low is lost
   task automatic t_freeze;
      ce <= 1'b0;
      host.put(1, 16'hC3C3);
      ce <= 1'b1;
      rdc(dpmb_pkg::IDX_IN1, 16'h9ABC);
      chk(n1, 1'b0);
   endtask
   // Verdict and end of run
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge clock_i);
      fails++;
      summarize();
   end
   // Main sequence
   initial begin
      repeat (6) @(posedge clock_i);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      t_reset();
      t_reserved();
      t_narrow();
      t_autoclear();
      t_out();
      t_irq();
      t_freeze();
      // Second reset in mid-run restores reset values
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      @(posedge clock_i);
      t_reset();
      chk(16'(host.n_late), 16'h0000);
      summarize();
   end
endmodule
